/* File: verilog/bms_top.sv */
/*
 * Boost mode supervisor: boost entry, soft start, light-load pulse
 * skipping, 32 s safety timer, boost faults, status pin pulse,
 * high-impedance mode and the crude host-presence timer.
 * Assumes host control bits arrive on sys_clk as levels or one-cycle
 * write pulses; pin and comparator inputs are asynchronous.
 */
//
// Operation
// - Boost when OTG pin or request bit set
// - Soft-start on every boost start-up
// - Skip switching below 75 mA, resume on droop
// - Start 32 s timer when boost begins
// - Kick restarts timer, kick bit self-clears
// - Timer expiry stops boost, pulses, sets fault
// - Timer fault latched until reset or clear
// - VBUS overvoltage stops boost, clears request
// - After overvoltage, restart on request or OTG
// - Overload fault only after 30 ms persistence
// - Overload fault stops boost until host clears
// - Battery out of range stops boost
// - After battery fault, restart on request/OTG
// - Status pin released; 128 us low per new fault, overlaps merge
// - High-impedance on request bit without OTG
// - Crude timer runs in high-Z at low battery
// - Crude expiry enters 32-minute mode
// - 32-minute mode and UVLO force high-Z
`timescale 1ns/1ns
module bms_top #(
    parameter int BOOST_TIMER_CYCLES = bms_pkg::BOOST_TMR_CYC,
    parameter int CRUDE_TIMER_CYCLES = bms_pkg::CRUDE_TMR_CYC,
    parameter int OVERLOAD_CYCLES = bms_pkg::OVL_FILTER_CYC,
    parameter int SOFT_START_CYCLES = bms_pkg::SOFT_START_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic otg_pin,
    input wire logic vbus_overvoltage,
    input wire logic vbus_overload,
    input wire logic battery_above_max,
    input wire logic battery_below_min,
    input wire logic battery_below_low,
    input wire logic vbus_below_uvlo,
    input wire logic inductor_current_low,
    input wire logic mid_rail_node_low,
    input wire logic boost_request_write,
    input wire logic boost_request_value,
    input wire logic timer_kick_write,
    input wire logic high_impedance_request_bit,
    input wire logic fault_clear,
    output logic boost_request_bit,
    output logic timer_kick_bit,
    output logic converter_enable,
    output logic switching_enable,
    output logic soft_start_active,
    output logic boost_mode,
    output logic high_impedance_mode,
    output logic minute_mode,
    output logic fault_timer,
    output logic fault_vbus_ovp,
    output logic fault_overload,
    output logic fault_battery,
    output logic stat_out,
    output logic stat_oe
);
    import bms_pkg::*;

    localparam int BW = $clog2(BOOST_TIMER_CYCLES + 1);
    localparam int CW = $clog2(CRUDE_TIMER_CYCLES + 1);
    localparam int OW = $clog2(OVERLOAD_CYCLES + 1);
    localparam int SW = $clog2(SOFT_START_CYCLES + 1);
    localparam int PW = $clog2(FAULT_PULSE_CYC + 1);

    // Two-stage synchroniser for every asynchronous input
    logic [IN_COUNT-1:0] async_in;
    logic [IN_COUNT-1:0] meta;
    logic [IN_COUNT-1:0] sync;

    assign async_in[IN_OTG] = otg_pin;
    assign async_in[IN_VBUS_OVP] = vbus_overvoltage;
    assign async_in[IN_OVERLOAD] = vbus_overload;
    assign async_in[IN_BAT_HIGH] = battery_above_max;
    assign async_in[IN_BAT_MIN] = battery_below_min;
    assign async_in[IN_BAT_LOW] = battery_below_low;
    assign async_in[IN_VBUS_UVLO] = vbus_below_uvlo;
    assign async_in[IN_IL_LOW] = inductor_current_low;
    assign async_in[IN_MID_RAIL_NODE_LOW] = mid_rail_node_low;

    always_ff @(posedge sys_clk) begin
        meta <= async_in;
        sync <= meta;
    end

    wire otg_active = sync[IN_OTG];
    wire ovp_now = sync[IN_VBUS_OVP];
    wire overload_now = sync[IN_OVERLOAD];
    wire bat_bad_now = sync[IN_BAT_HIGH] | sync[IN_BAT_MIN];
    wire bat_low_now = sync[IN_BAT_LOW];
    wire uvlo_now = sync[IN_VBUS_UVLO];
    wire il_low_now = sync[IN_IL_LOW];
    wire mid_rail_node_low_now = sync[IN_MID_RAIL_NODE_LOW];

    bms_state_t state;
    bms_state_t next_state;

    logic [BW-1:0] boost_cnt;
    logic [CW-1:0] crude_cnt;
    logic [OW-1:0] ovl_cnt;
    logic [SW-1:0] soft_cnt;
    logic [PW-1:0] pulse_cnt;
    logic pulse_skip;

    wire boosting = (state == BMS_SOFT) | (state == BMS_RUN);

    // Fault events; overload must outlast its filter first
    wire boost_expired = boosting &
        (boost_cnt == BW'(BOOST_TIMER_CYCLES - 1)) & ~timer_kick_bit;
    wire ovl_expired = boosting & overload_now &
        (ovl_cnt == OW'(OVERLOAD_CYCLES));
    wire ovp_event = boosting & ovp_now;
    wire bat_event = boosting & bat_bad_now;
    wire any_stop = boost_expired | ovl_expired | ovp_event | bat_event;

    // Latched timer and overload faults block until cleared; live OVP and battery conditions block too
    wire blocked = fault_timer | fault_overload | ovp_now | bat_bad_now;

    wire hiz_wanted = (high_impedance_request_bit & ~otg_active)
        | (minute_mode & uvlo_now);
    wire boost_wanted = (boost_request_bit | otg_active) & ~minute_mode;
    wire boost_go = boost_wanted & ~hiz_wanted & ~blocked;

    wire soft_done = soft_cnt == SW'(SOFT_START_CYCLES - 1);
    wire crude_run = (state == BMS_HIZ) & bat_low_now & ~minute_mode;
    wire crude_expired = crude_run &
        (crude_cnt == CW'(CRUDE_TIMER_CYCLES - 1));

    // A fault bit rising from clear to set starts the status pulse
    wire set_timer = boost_expired;
    wire set_ovl = ovl_expired;
    wire set_ovp = ovp_event;
    wire set_bat = bat_event;
    wire new_fault = (set_timer & ~fault_timer) | (set_ovl & ~fault_overload)
        | (set_ovp & ~fault_vbus_ovp) | (set_bat & ~fault_battery);
    wire pulse_busy = pulse_cnt != '0;
    wire pulse_start = new_fault & ~pulse_busy;

    always_comb begin
        next_state = state;
        case (state)
            BMS_IDLE: begin
                if (hiz_wanted) begin
                    next_state = BMS_HIZ;
                end else if (boost_go) begin
                    next_state = BMS_SOFT;
                end
            end
            BMS_SOFT: begin
                if (any_stop | hiz_wanted | ~boost_wanted) begin
                    next_state = BMS_IDLE;
                end else if (soft_done) begin
                    next_state = BMS_RUN;
                end
            end
            BMS_RUN: begin
                if (any_stop | hiz_wanted | ~boost_wanted) begin
                    next_state = BMS_IDLE;
                end
            end
            BMS_HIZ: begin
                if (~hiz_wanted) begin
                    next_state = BMS_IDLE;
                end
            end
            default: begin
                next_state = BMS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= BMS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Soft-start length counter, restarted on every entry
    always_ff @(posedge sys_clk) begin
        if (rst || state != BMS_SOFT) begin
            soft_cnt <= '0;
        end else if (!soft_done) begin
            soft_cnt <= soft_cnt + SW'(1);
        end
    end

    // Safety timer: zero while idle, so each boost starts fresh
    always_ff @(posedge sys_clk) begin
        if (rst || !boosting || timer_kick_bit) begin
            boost_cnt <= '0;
        end else if (!boost_expired) begin
            boost_cnt <= boost_cnt + BW'(1);
        end
    end

    // Kick bit holds one cycle, then hardware clears it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_kick_bit <= 1'b0;
        end else begin
            timer_kick_bit <= timer_kick_write;
        end
    end

    // Overload filter: any gap in the condition restarts the count
    always_ff @(posedge sys_clk) begin
        if (rst || !boosting || !overload_now) begin
            ovl_cnt <= '0;
        end else if (ovl_cnt != OW'(OVERLOAD_CYCLES)) begin
            ovl_cnt <= ovl_cnt + OW'(1);
        end
    end

    // Crude timer restarts whenever its enabling condition drops
    always_ff @(posedge sys_clk) begin
        if (rst || !crude_run) begin
            crude_cnt <= '0;
        end else if (!crude_expired) begin
            crude_cnt <= crude_cnt + CW'(1);
        end
    end

    // A kick proves the host is present and leaves 32-minute mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            minute_mode <= 1'b0;
        end else if (crude_expired) begin
            minute_mode <= 1'b1;
        end else if (timer_kick_write) begin
            minute_mode <= 1'b0;
        end
    end

    // Hardware clear beats a host write so a fault cannot be undone
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            boost_request_bit <= 1'b0;
        end else if (ovl_expired | ovp_event | bat_event) begin
            boost_request_bit <= 1'b0;
        end else if (boost_request_write) begin
            boost_request_bit <= boost_request_value;
        end
    end

    // Sticky fault bits: a set in the clear cycle wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fault_timer <= 1'b0;
            fault_overload <= 1'b0;
            fault_vbus_ovp <= 1'b0;
            fault_battery <= 1'b0;
        end else begin
            fault_timer <= set_timer | (fault_timer & ~fault_clear);
            fault_overload <= set_ovl | (fault_overload & ~fault_clear);
            fault_vbus_ovp <= set_ovp | (fault_vbus_ovp & ~fault_clear);
            fault_battery <= set_bat | (fault_battery & ~fault_clear);
        end
    end

    // Pulse skipping: stop below light-load current, resume on droop
    always_ff @(posedge sys_clk) begin
        if (rst || state != BMS_RUN) begin
            pulse_skip <= 1'b0;
        end else if (mid_rail_node_low_now) begin
            pulse_skip <= 1'b0;
        end else if (il_low_now) begin
            pulse_skip <= 1'b1;
        end
    end

    // Status pulse; onsets during a running pulse merge into it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pulse_cnt <= '0;
        end else if (pulse_start) begin
            pulse_cnt <= PW'(FAULT_PULSE_CYC);
        end else if (pulse_busy) begin
            pulse_cnt <= pulse_cnt - PW'(1);
        end
    end

    // Registered power-stage controls follow the next state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            converter_enable <= 1'b0;
            switching_enable <= 1'b0;
            soft_start_active <= 1'b0;
            boost_mode <= 1'b0;
            high_impedance_mode <= 1'b0;
            stat_out <= 1'b0;
            stat_oe <= 1'b0;
        end else begin
            converter_enable <= (next_state == BMS_SOFT) |
                (next_state == BMS_RUN);
            switching_enable <= (next_state == BMS_SOFT) |
                ((next_state == BMS_RUN) & ~pulse_skip);
            soft_start_active <= next_state == BMS_SOFT;
            boost_mode <= (next_state == BMS_SOFT) | (next_state == BMS_RUN);
            high_impedance_mode <= next_state == BMS_HIZ;
            stat_out <= 1'b0;
            stat_oe <= pulse_start | (pulse_cnt > PW'(1));
        end
    end

endmodule

/* File: shared/bms_pkg.sv */
/*
 * Shared constants and types for the boost mode supervisor.
 * Assumes a 25 MHz system clock; all cycle counts derive from it.
 */
package bms_pkg;

    localparam longint CLK_HZ = 25_000_000;
    localparam longint MS_PER_S = 1_000;
    localparam longint US_PER_S = 1_000_000;

    // Times as specified, in their own units
    localparam longint BOOST_TMR_S = 32;
    localparam longint CRUDE_TMR_S = 32;
    localparam longint OVL_FILTER_MS = 30;
    localparam longint FAULT_PULSE_US = 128;
    localparam longint SOFT_START_US = 1_000;

    // Cycle counts; least times round up
    localparam int BOOST_TMR_CYC = int'(BOOST_TMR_S * CLK_HZ);
    localparam int CRUDE_TMR_CYC = int'(CRUDE_TMR_S * CLK_HZ);
    localparam int OVL_FILTER_CYC =
        int'((OVL_FILTER_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S);
    localparam int FAULT_PULSE_CYC =
        int'((FAULT_PULSE_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
    localparam int SOFT_START_CYC =
        int'((SOFT_START_US * CLK_HZ + US_PER_S - 1) / US_PER_S);

    // Positions of the asynchronous inputs in the synchroniser vector
    localparam int IN_OTG = 0;
    localparam int IN_VBUS_OVP = 1;
    localparam int IN_OVERLOAD = 2;
    localparam int IN_BAT_HIGH = 3;
    localparam int IN_BAT_MIN = 4;
    localparam int IN_BAT_LOW = 5;
    localparam int IN_VBUS_UVLO = 6;
    localparam int IN_IL_LOW = 7;
    localparam int IN_MID_RAIL_NODE_LOW = 8;
    localparam int IN_COUNT = 9;

    typedef enum logic [1:0] {
        BMS_IDLE,
        BMS_SOFT,
        BMS_RUN,
        BMS_HIZ
    } bms_state_t;

endpackage

/* File: sim/bms_asserts.sv */
/* Port checker for bms_top: kick bit, soft start, fault pulse,
   overload filter and high-impedance entry.
   Bound to bms_top from the bench; sees its ports only. */
`timescale 1ns/1ns
module bms_asserts
    import bms_pkg::*;
#(
    parameter int OVERLOAD_CYCLES = 50
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic otg_pin,
    input wire logic vbus_overload,
    input wire logic vbus_below_uvlo,
    input wire logic timer_kick_write,
    input wire logic high_impedance_request_bit,
    input wire logic timer_kick_bit,
    input wire logic converter_enable,
    input wire logic soft_start_active,
    input wire logic minute_mode,
    input wire logic high_impedance_mode,
    input wire logic fault_timer,
    input wire logic fault_vbus_ovp,
    input wire logic fault_overload,
    input wire logic fault_battery,
    input wire logic stat_out,
    input wire logic stat_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    int pulse_len;
    int ovl_run;
    wire any_fault = fault_timer | fault_vbus_ovp | fault_overload
        | fault_battery;
    // Raw run length; the input synchroniser only lengthens it
    always_ff @(posedge sys_clk) begin
        pulse_len <= (rst || !stat_oe) ? 0 : pulse_len + 1;
        ovl_run <= (rst || !vbus_overload) ? 0 : ovl_run + 1;
    end
    property p_open_drain; stat_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("status data not low");
    property p_kick; timer_kick_write |=> timer_kick_bit; endproperty
    a_kick: assert property (p_kick)
        else $error("kick bit not set");
    property p_pulse_len; $fell(stat_oe) |-> pulse_len == 3200; endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("fault pulse length wrong");
    property p_pulse_cause; $rose(stat_oe) |-> any_fault; endproperty
    a_pulse_cause: assert property (p_pulse_cause)
        else $error("pulse without fault");
    property p_soft; $rose(converter_enable) |-> soft_start_active; endproperty
    a_soft: assert property (p_soft)
        else $error("start without soft start");
    property p_blocked;
        (fault_timer || fault_overload) |-> !converter_enable;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("boost while fault latched");
    property p_ovl; $rose(fault_overload) |-> ovl_run > OVERLOAD_CYCLES;
    endproperty
    a_ovl: assert property (p_ovl)
        else $error("overload fault too early");
    property p_hiz;
        (high_impedance_request_bit && !otg_pin)[*6] |-> high_impedance_mode;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("high impedance not entered");
    property p_uvlo;
        (minute_mode && vbus_below_uvlo)[*6] |-> high_impedance_mode;
    endproperty
    a_uvlo: assert property (p_uvlo)
        else $error("undervoltage high impedance missing");
    c_pulse: cover property ($rose(stat_oe));
    c_minute: cover property ($rose(minute_mode));
    c_ovl: cover property ($rose(fault_overload));
endmodule

/* File: sim/bms_host.sv */
/* Host processor model: writes the boost request, kicks the safety
   timer, clears faults and sets the high-impedance bit.
   Changes its outputs only at falling edges of sys_clk. */
`timescale 1ns/1ns
module bms_host (
    input wire logic sys_clk,
    output logic req_wr,
    output logic req_val,
    output logic kick_wr,
    output logic hz_bit,
    output logic clr
);
    initial {req_wr, req_val, kick_wr, hz_bit, clr} = 5'h00;
    // One-cycle write: sel picks request, kick or fault clear
    task automatic strobe(input logic [2:0] sel, input logic v);
        @(negedge sys_clk);
        {clr, kick_wr, req_wr} = sel;
        req_val = v;
        @(negedge sys_clk);
        {clr, kick_wr, req_wr} = 3'h0;
    endtask
    task automatic set_hz(input logic v);
        @(negedge sys_clk);
        hz_bit = v;
    endtask
endmodule

/* File: sim/boost_mode_supervisor_tb.sv */
/* Self-checking bench for bms_top with short timer parameters.
   Host bits come from bms_host; comparator inputs from here. */
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAIT(c, n) begin k = 0; while (!(c) && k < (n)) begin \
    @(negedge sys_clk); k++; end if (!(c)) begin bad_count++; \
    give_verdict(); end end
module boost_mode_supervisor_tb;
    localparam int BT = 200;
    localparam int CT = 200;
    localparam int OV = 50;
    localparam int SS = 10;
    logic sys_clk = 1'b0;
    logic rst, otg_pin, vbus_overload, battery_below_low, vbus_below_uvlo;
    logic inductor_current_low, mid_rail_node_low;
    logic [2:0] flt;
    wire battery_below_min, battery_above_max, vbus_overvoltage;
    wire boost_request_write, boost_request_value, timer_kick_write;
    wire high_impedance_request_bit, fault_clear;
    logic boost_request_bit, timer_kick_bit, converter_enable;
    logic switching_enable, soft_start_active, boost_mode, minute_mode;
    logic high_impedance_mode, fault_timer, fault_vbus_ovp, fault_overload;
    logic fault_battery, stat_out, stat_oe;
    int bad_count = 0;
    int checked = 0;
    int pulses = 0;
    int k;
    assign {battery_below_min, battery_above_max, vbus_overvoltage} = flt;
    always #20 sys_clk = ~sys_clk;
    always @(posedge stat_oe) pulses++;
    bms_top #(.BOOST_TIMER_CYCLES(BT), .CRUDE_TIMER_CYCLES(CT),
        .OVERLOAD_CYCLES(OV), .SOFT_START_CYCLES(SS)) DUT (.*);
    bms_host HOST (.sys_clk(sys_clk), .req_wr(boost_request_write),
        .req_val(boost_request_value), .kick_wr(timer_kick_write),
        .hz_bit(high_impedance_request_bit), .clr(fault_clear));
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic give_verdict();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        {otg_pin, vbus_overload, battery_below_low, vbus_below_uvlo} = 4'h0;
        {inductor_current_low, mid_rail_node_low, flt} = 5'h00;
        rst = 1'b1;
        idle(3);
        rst = 1'b0;
        HOST.strobe(3'h1, 1'b1);
        `CHK(boost_request_bit, 1'b1)
        `WAIT(converter_enable, 5)
        `CHK(soft_start_active, 1'b1)
        `CHK(boost_mode, 1'b1)
        `WAIT(!soft_start_active, SS + 3)
        `CHK(switching_enable, 1'b1)
        inductor_current_low = 1'b1;
        idle(4);
        `CHK(switching_enable, 1'b0)
        mid_rail_node_low = 1'b1;
        idle(4);
        `CHK(switching_enable, 1'b1)
        {inductor_current_low, mid_rail_node_low} = 2'h0;
        repeat (4) begin
            idle(BT - 60);
            HOST.strobe(3'h2, 1'b0);
            `CHK(timer_kick_bit, 1'b1)
            idle(1);
            `CHK(timer_kick_bit, 1'b0)
        end
        `CHK(converter_enable, 1'b1)
        `WAIT(stat_oe, BT + 5)
        `CHK(fault_timer, 1'b1)
        `CHK(converter_enable, 1'b0)
        `CHK(stat_out, 1'b0)
        `WAIT(!stat_oe, 3300)
        `CHK(fault_timer, 1'b1)
        `CHK(converter_enable, 1'b0)
        HOST.strobe(3'h4, 1'b0);
        `WAIT(converter_enable, 8)
        `CHK(fault_timer, 1'b0)
        // Overvoltage, battery high, battery below minimum; OTG restarts the last
        for (int i = 0; i < 3; i++) begin
            HOST.strobe(3'h2, 1'b0);
            otg_pin = (i == 2);
            flt[i] = 1'b1;
            `WAIT(!converter_enable, 6)
            `CHK(boost_request_bit, 1'b0)
            `CHK({fault_vbus_ovp, fault_battery}, (i == 0) ? 2'h2 : 2'h1)
            idle(4000);
            `CHK(pulses, 2 + i)
            flt[i] = 1'b0;
            idle(10);
            `CHK(converter_enable, i == 2)
            HOST.strobe(3'h4, 1'b0);
            if (i < 2) HOST.strobe(3'h1, 1'b1);
            `WAIT(converter_enable, 8)
            `CHK(converter_enable, 1'b1)
        end
        vbus_overload = 1'b1;
        idle(30);
        vbus_overload = 1'b0;
        `CHK(fault_overload, 1'b0)
        // A real gap, so the filter must restart from zero
        idle(4);
        vbus_overload = 1'b1;
        `WAIT(fault_overload, OV + 10)
        `CHK(converter_enable, 1'b0)
        vbus_overload = 1'b0;
        `WAIT(!stat_oe, 3300)
        `CHK(converter_enable, 1'b0)
        `CHK(pulses, 5)
        HOST.strobe(3'h4, 1'b0);
        `WAIT(converter_enable, 8)
        HOST.set_hz(1'b1);
        idle(8);
        `CHK(high_impedance_mode, 1'b0)
        otg_pin = 1'b0;
        `WAIT(high_impedance_mode, 8)
        `CHK(converter_enable, 1'b0)
        battery_below_low = 1'b1;
        idle(CT - 20);
        `CHK(minute_mode, 1'b0)
        `WAIT(minute_mode, 40)
        `CHK(minute_mode, 1'b1)
        vbus_below_uvlo = 1'b1;
        idle(4);
        HOST.set_hz(1'b0);
        idle(8);
        `CHK(high_impedance_mode, 1'b1)
        vbus_below_uvlo = 1'b0;
        `WAIT(!high_impedance_mode, 8)
        HOST.strobe(3'h1, 1'b1);
        idle(8);
        `CHK(converter_enable, 1'b0)
        HOST.strobe(3'h2, 1'b0);
        `WAIT(converter_enable, 8)
        `CHK(minute_mode, 1'b0)
        give_verdict();
    end
endmodule
bind bms_top bms_asserts #(.OVERLOAD_CYCLES(OVERLOAD_CYCLES)) u_chk (.*);
